//--- hdl/edcl_consts.svh
// Constants for the engine discrete command logic: offsets, fields, resets, timing.
`ifndef EDCL_CONSTS_SVH
`define EDCL_CONSTS_SVH
`define EDCL_CLK_HZ 10000000
`define EDCL_START_TIME_S 10
`define EDCL_BOOT_TIME_S 30
`define EDCL_DEBOUNCE_MS 10
`define EDCL_OFF_CTRL 12'h000
`define EDCL_OFF_CFG 12'h004
`define EDCL_OFF_SPD_LIM 12'h008
`define EDCL_OFF_LOAD_SET 12'h00c
`define EDCL_OFF_RATE 12'h010
`define EDCL_OFF_STATUS 12'h014
`define EDCL_OFF_REFS 12'h018
`define EDCL_OFF_SPEED 12'h01c
`define EDCL_CTRL_SW_RESET 0
`define EDCL_CFG_MAP_LSB 0
`define EDCL_CFG_MAT_LSB 2
`define EDCL_CFG_ACT_LSB 4
`define EDCL_CFG_REVERSE 6
`define EDCL_CFG_ALT_FUNC 7
`define EDCL_CFG_RESET 32'h0000_0000
`define EDCL_SPD_LIM_RESET 32'h0708_05dc
`define EDCL_LOAD_SET_RESET 16'h0200
`define EDCL_RATE_RESET 32'h0001_0001
`define EDCL_SPD_REF_RESET 16'h05dc
`define EDCL_UNLOAD_LEVEL 16'h0010
`define EDCL_SHARE_LEVEL 16'h0100
`define EDCL_RAMP_DIV 16'd1000
`endif

//--- hdl/edcl_pkg.sv
// Types shared by the engine discrete command logic.
package edcl_pkg;
    typedef enum logic [1:0] {
        EDCL_BOOT = 2'b00,
        EDCL_IDLE = 2'b01,
        EDCL_START = 2'b11,
        EDCL_RUN = 2'b10
    } edcl_state_t;
    typedef enum logic [1:0] {
        EDCL_IN_0_5V = 2'h0,
        EDCL_IN_1_5V = 2'h1,
        EDCL_IN_4_20MA = 2'h2,
        EDCL_IN_PM2V5 = 2'h3
    } edcl_in_type_t;
    typedef enum logic [1:0] {
        EDCL_ACT_0_200MA = 2'h0,
        EDCL_ACT_0_20MA = 2'h1,
        EDCL_ACT_4_20MA = 2'h2
    } edcl_act_range_t;
endpackage

//--- hdl/edcl_core.sv
// Discrete command interpreter with an AHB-Lite register slave.
`timescale 1ns/10ps
`include "edcl_consts.svh"
module edcl_core
    import edcl_pkg::*;
#(
    parameter int unsigned START_CYCLES = `EDCL_START_TIME_S * `EDCL_CLK_HZ,
    parameter int unsigned BOOT_CYCLES = `EDCL_BOOT_TIME_S * `EDCL_CLK_HZ,
    parameter int unsigned DEBOUNCE_CYCLES = `EDCL_DEBOUNCE_MS * (`EDCL_CLK_HZ / 1000),
    parameter int unsigned RAMP_CYCLES = `EDCL_RAMP_DIV
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Discrete contact inputs, asynchronous.
    input wire logic run_enable_in,
    input wire logic reset_in,
    input wire logic breaker_in,
    input wire logic base_load_in,
    input wire logic raise_in,
    input wire logic lower_in,
    input wire logic load_unload_in,
    input wire logic load_only_control_in,
    // Measurement and fault events from the control core.
    input wire logic [15:0] engine_speed,
    input wire logic speed_pickup_seen,
    input wire logic overspeed_event,
    input wire logic alarm_event,
    // Mode, fault and reference outputs.
    output logic fuel_enable,
    output logic mixture_close,
    output logic isoch_mode,
    output logic dynamics_set2,
    output logic base_load_mode,
    output logic load_only_mode,
    output logic load_sharing_en,
    output logic gas_quality_closed_loop_en,
    output logic speed_pickup_fault,
    output logic overspeed_sd,
    output logic alarm_latched,
    output logic io_locked,
    output logic [15:0] speed_ref,
    output logic [15:0] load_ref
);

    localparam int unsigned NIN = 8;
    logic [NIN-1:0] raw, s1_q, s2_q, clean_q;
    logic [NIN-1:0][23:0] db_cnt_q;
    assign raw = {load_only_control_in, load_unload_in, lower_in, raise_in,
                  base_load_in, breaker_in, reset_in, run_enable_in};

    // Two-flop synchronisers; only the second stage is read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    // Debounce: a new level must hold steady for the whole window before it counts.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clean_q <= '0;
            db_cnt_q <= '0;
        end else begin
            for (int i = 0; i < NIN; i++) begin
                if (s2_q[i] == clean_q[i]) begin
                    db_cnt_q[i] <= '0;
                end else if (db_cnt_q[i] >= 24'(DEBOUNCE_CYCLES - 1)) begin
                    clean_q[i] <= s2_q[i];
                    db_cnt_q[i] <= '0;
                end else begin
                    db_cnt_q[i] <= db_cnt_q[i] + 24'h1;
                end
            end
        end
    end

    logic run, rst_in, brk, bl, rais, lowr, ldul, kw;
    assign {kw, ldul, lowr, rais, bl, brk, rst_in, run} = clean_q;

    // Registers written by software.
    logic [31:0] cfg_q, spd_lim_q, rate_q;
    logic [15:0] load_set_q, load_set_act_q;
    logic sw_reset_q;
    logic alt_func;
    assign alt_func = cfg_q[`EDCL_CFG_ALT_FUNC];

    // AHB-Lite address phase capture; answers in the next cycle, zero wait states.
    logic ap_wr_q, ap_rd_q;
    logic [11:0] ap_addr_q;
    logic take;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q <= 1'b0;
            ap_rd_q <= 1'b0;
            ap_addr_q <= 12'h000;
        end else begin
            ap_wr_q <= take && hwrite;
            ap_rd_q <= take && !hwrite;
            ap_addr_q <= haddr;
        end
    end

    // Register writes in the data phase; the reset command is a one-cycle pulse.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= `EDCL_CFG_RESET;
            spd_lim_q <= `EDCL_SPD_LIM_RESET;
            load_set_q <= `EDCL_LOAD_SET_RESET;
            rate_q <= `EDCL_RATE_RESET;
            sw_reset_q <= 1'b0;
        end else begin
            sw_reset_q <= 1'b0;
            if (ap_wr_q) begin
                case (ap_addr_q)
                    `EDCL_OFF_CTRL: sw_reset_q <= hwdata[`EDCL_CTRL_SW_RESET];
                    `EDCL_OFF_CFG: cfg_q <= {24'h0, hwdata[7:0]};
                    `EDCL_OFF_SPD_LIM: spd_lim_q <= hwdata;
                    `EDCL_OFF_LOAD_SET: load_set_q <= hwdata[15:0];
                    `EDCL_OFF_RATE: rate_q <= hwdata;
                    default: ;
                endcase
            end
        end
    end

    // Run sequencing: boot lock, idle, start window, running.
    edcl_state_t st_q;
    logic [31:0] tmr_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= EDCL_BOOT;
            tmr_q <= '0;
        end else begin
            case (st_q)
                EDCL_BOOT: begin
                    if (tmr_q >= BOOT_CYCLES - 1) begin
                        st_q <= EDCL_IDLE;
                        tmr_q <= '0;
                    end else begin
                        tmr_q <= tmr_q + 32'h1;
                    end
                end
                EDCL_IDLE: begin
                    tmr_q <= '0;
                    if (run) begin
                        st_q <= EDCL_START;
                    end
                end
                EDCL_START: begin
                    tmr_q <= tmr_q + 32'h1;
                    if (!run) begin
                        st_q <= EDCL_IDLE;
                    end else if (tmr_q >= START_CYCLES - 1) begin
                        st_q <= EDCL_RUN;
                    end
                end
                EDCL_RUN: begin
                    if (!run) begin
                        st_q <= EDCL_IDLE;
                    end
                end
                default: st_q <= EDCL_BOOT;
            endcase
        end
    end

    // Latched faults; a new event wins over a clear in the same cycle.
    logic clr;
    assign clr = rst_in || sw_reset_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_pickup_fault <= 1'b0;
            overspeed_sd <= 1'b0;
            alarm_latched <= 1'b0;
        end else begin
            if (st_q == EDCL_START && tmr_q >= START_CYCLES - 1 && !speed_pickup_seen) begin
                speed_pickup_fault <= 1'b1;
            end else if (st_q == EDCL_RUN && !speed_pickup_seen) begin
                speed_pickup_fault <= 1'b1;
            end else if (clr) begin
                speed_pickup_fault <= 1'b0;
            end
            if (overspeed_event) begin
                overspeed_sd <= 1'b1;
            end else if (clr && engine_speed == 16'h0000) begin
                overspeed_sd <= 1'b0;
            end
            if (alarm_event) begin
                alarm_latched <= 1'b1;
            end else if (clr) begin
                alarm_latched <= 1'b0;
            end
        end
    end

    // Mode decode; breaker gates load-only, base load and load/unload.
    logic ready, bl_sel, kw_sel, bl_prev_q;
    assign ready = st_q != EDCL_BOOT;
    assign kw_sel = brk && kw;
    assign bl_sel = brk && kw && bl && !alt_func;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuel_enable <= 1'b0;
            mixture_close <= 1'b1;
            isoch_mode <= 1'b0;
            dynamics_set2 <= 1'b0;
            base_load_mode <= 1'b0;
            load_only_mode <= 1'b0;
            load_sharing_en <= 1'b0;
            gas_quality_closed_loop_en <= 1'b0;
            io_locked <= 1'b1;
            bl_prev_q <= 1'b0;
        end else begin
            io_locked <= !ready;
            fuel_enable <= ready && run && !speed_pickup_fault && !overspeed_sd;
            mixture_close <= !(ready && run);
            isoch_mode <= ready && brk && !kw_sel;
            dynamics_set2 <= brk;
            base_load_mode <= bl_sel;
            load_only_mode <= kw_sel;
            load_sharing_en <= ready && brk && !kw_sel && ldul;
            gas_quality_closed_loop_en <= ready && !(alt_func && bl);
            bl_prev_q <= bl_sel;
        end
    end

    // Setpoint in use changes only on entry to base load.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_set_act_q <= `EDCL_LOAD_SET_RESET;
        end else if (bl_sel && !bl_prev_q) begin
            load_set_act_q <= load_set_q;
        end
    end

    // Ramp tick: references step once per tick, the load reference by the configured rates and the speed reference by one.
    logic [15:0] tick_cnt_q;
    logic tick;
    assign tick = tick_cnt_q == 16'(RAMP_CYCLES - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h1;
        end
    end

    // Speed reference ramp while the breaker is open, clamped to the limits.
    logic [15:0] lo_lim, hi_lim;
    assign lo_lim = spd_lim_q[15:0];
    assign hi_lim = spd_lim_q[31:16];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_ref <= `EDCL_SPD_REF_RESET;
        end else if (tick && ready && !brk && (rais != lowr)) begin
            if (rais) begin
                speed_ref <= (speed_ref >= hi_lim) ? hi_lim : speed_ref + 16'h1;
            end else begin
                speed_ref <= (speed_ref <= lo_lim) ? lo_lim : speed_ref - 16'h1;
            end
        end
    end

    // Load reference: base load target, else raise/lower, else load/unload target.
    logic [15:0] up_r, dn_r, tgt;
    assign up_r = rate_q[15:0];
    assign dn_r = rate_q[31:16];
    assign tgt = !ldul ? `EDCL_UNLOAD_LEVEL : (bl_sel ? load_set_act_q : `EDCL_SHARE_LEVEL);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_ref <= '0;
        end else if (tick && ready && brk) begin
            if (bl_sel && ldul) begin
                // Raise and lower have no effect here.
                if (load_ref < tgt) begin
                    load_ref <= (tgt - load_ref > up_r) ? load_ref + up_r : tgt;
                end else begin
                    load_ref <= (load_ref - tgt > dn_r) ? load_ref - dn_r : tgt;
                end
            end else if (kw_sel && (rais != lowr)) begin
                if (rais) begin
                    load_ref <= (16'hffff - load_ref > up_r) ? load_ref + up_r : 16'hffff;
                end else begin
                    load_ref <= (load_ref > dn_r) ? load_ref - dn_r : 16'h0000;
                end
            end else if (!kw_sel || !ldul) begin
                // Load/unload drives the ramp outside load-only, and in load-only with load/unload open and no raise or lower.
                if (load_ref < tgt) begin
                    load_ref <= (tgt - load_ref > up_r) ? load_ref + up_r : tgt;
                end else if (load_ref > tgt) begin
                    load_ref <= (load_ref - tgt > dn_r) ? load_ref - dn_r : tgt;
                end
            end
            // Otherwise load-only with load/unload closed, outside base load, no raise or lower: the reference holds where it is.
        end
    end

    // Read data is chosen in the address phase and registered, so it stands in the data phase.
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        case (haddr)
            `EDCL_OFF_CFG: rd_d = cfg_q;
            `EDCL_OFF_SPD_LIM: rd_d = spd_lim_q;
            `EDCL_OFF_LOAD_SET: rd_d = {16'h0000, load_set_q};
            `EDCL_OFF_RATE: rd_d = rate_q;
            `EDCL_OFF_STATUS: rd_d = {16'h0000, clean_q, st_q, io_locked, alarm_latched,
                                      overspeed_sd, speed_pickup_fault, base_load_mode,
                                      load_only_mode};
            `EDCL_OFF_REFS: rd_d = {load_ref, speed_ref};
            `EDCL_OFF_SPEED: rd_d = {16'h0000, engine_speed};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= (take && !hwrite) ? rd_d : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule

//--- tb/edcl_core_monitor.sv
// Port checker for the engine discrete command logic, bound to the core.
`timescale 1ns/10ps
module edcl_core_monitor (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Contact and measurement inputs.
    input wire logic run_enable_in,
    input wire logic breaker_in,
    input wire logic raise_in,
    input wire logic lower_in,
    input wire logic [15:0] engine_speed,
    // Mode, fault and reference outputs.
    input wire logic fuel_enable,
    input wire logic mixture_close,
    input wire logic isoch_mode,
    input wire logic dynamics_set2,
    input wire logic base_load_mode,
    input wire logic load_only_mode,
    input wire logic load_sharing_en,
    input wire logic speed_pickup_fault,
    input wire logic overspeed_sd,
    input wire logic io_locked,
    input wire logic [15:0] speed_ref
);
    // All checks share the bus clock; reset silences them.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Windows of eight input cycles leave room for synchroniser and debounce latency.
    property p_lock_fuel; io_locked |-> !fuel_enable; endproperty
    a_lock_fuel: assert property (p_lock_fuel) else $error("fuel while locked");
    property p_mix_fuel; mixture_close |-> !fuel_enable; endproperty
    a_mix_fuel: assert property (p_mix_fuel) else $error("fuel with mixture closed");
    property p_run_off; !run_enable_in [*8] |=> mixture_close; endproperty
    a_run_off: assert property (p_run_off) else $error("mixture open without run");
    property p_brk_off;
        !breaker_in [*8] |=> !isoch_mode && !dynamics_set2 && !base_load_mode && !load_only_mode;
    endproperty
    a_brk_off: assert property (p_brk_off) else $error("breaker modes without breaker");
    property p_base_only; base_load_mode |-> load_only_mode && !load_sharing_en; endproperty
    a_base_only: assert property (p_base_only) else $error("base load without load only");
    property p_share_off; load_only_mode |-> !load_sharing_en; endproperty
    a_share_off: assert property (p_share_off) else $error("sharing in load only");
    property p_pick_hold;
        $fell(mixture_close) && !speed_pickup_fault |=> !speed_pickup_fault [*8];
    endproperty
    a_pick_hold: assert property (p_pick_hold) else $error("pickup fault during start");
    property p_ovs_keep; overspeed_sd && engine_speed != 16'h0 |=> overspeed_sd; endproperty
    a_ovs_keep: assert property (p_ovs_keep) else $error("overspeed cleared at speed");
    property p_ref_hold; (!raise_in && !lower_in) [*8] |=> $stable(speed_ref); endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("speed reference moved idle");
endmodule

bind edcl_core edcl_core_monitor mon_u (.hclk, .hresetn, .run_enable_in, .breaker_in,
    .raise_in, .lower_in, .engine_speed, .fuel_enable, .mixture_close, .isoch_mode,
    .dynamics_set2, .base_load_mode, .load_only_mode, .load_sharing_en, .speed_pickup_fault,
    .overspeed_sd, .io_locked, .speed_ref);

//--- tb/edcl_contacts.sv
// Model of the external switch and relay contacts on the discrete inputs.
`timescale 1ns/10ps
module edcl_contacts (
    // Clock.
    input wire logic hclk,
    // Contact levels, high while closed and energised.
    output logic [7:0] contact
);
    initial contact = 8'h00;
    // Every change bounces twice, as a real contact does, to exercise the debounce.
    task automatic flip(input int idx, input logic closed);
        repeat (2) begin
            @(posedge hclk);
            contact[idx] <= closed;
            @(posedge hclk);
            contact[idx] <= !closed;
        end
        @(posedge hclk);
        contact[idx] <= closed;
    endtask
endmodule

//--- tb/edcl_core_tb.sv
// Self-checking bench for the engine discrete command logic.
`timescale 1ns/10ps
`include "edcl_consts.svh"
module edcl_core_tb;
    localparam int RUN = 0, RST = 1, BRK = 2, BASE = 3, RAISE = 4, LOWER = 5, LU = 6, LOC = 7;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, seen, ovs_ev, alm_ev;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:0] contact;
    logic [15:0] engine_speed, speed_ref, load_ref, v;
    logic fuel_enable, mixture_close, isoch_mode, dynamics_set2, base_load_mode;
    logic load_only_mode, load_sharing_en, gql_en, pick_flt, overspeed_sd, alarm_latched;
    logic io_locked;
    int error_cnt = 0;
    int checked = 0;

    edcl_core #(.START_CYCLES(50), .BOOT_CYCLES(20), .DEBOUNCE_CYCLES(3), .RAMP_CYCLES(4)) dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .run_enable_in(contact[RUN]), .reset_in(contact[RST]), .breaker_in(contact[BRK]),
        .base_load_in(contact[BASE]), .raise_in(contact[RAISE]), .lower_in(contact[LOWER]),
        .load_unload_in(contact[LU]), .load_only_control_in(contact[LOC]),
        .engine_speed, .speed_pickup_seen(seen), .overspeed_event(ovs_ev),
        .alarm_event(alm_ev), .fuel_enable, .mixture_close, .isoch_mode, .dynamics_set2,
        .base_load_mode, .load_only_mode, .load_sharing_en,
        .gas_quality_closed_loop_en(gql_en), .speed_pickup_fault(pick_flt), .overspeed_sd,
        .alarm_latched, .io_locked, .speed_ref, .load_ref);
    edcl_contacts sw_u (.hclk, .contact);

    // Free-running 10 MHz clock.
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Compare, count and report.
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    task summarize;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Bounded waits; a wait that runs out is a mismatch and ends the run.
    task automatic wait1(ref logic s, input logic e);
        for (int n = 0; n < 3000 && s !== e; n++) @(negedge hclk);
        check({31'h0, s}, {31'h0, e});
        if (s !== e) summarize();
    endtask

    task automatic wait16(ref logic [15:0] s, input logic [15:0] e);
        for (int n = 0; n < 3000 && s !== e; n++) @(negedge hclk);
        check({16'h0, s}, {16'h0, e});
        if (s !== e) summarize();
    endtask

    // One AHB-Lite single word transfer; read data lands in rd.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 200);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
        // A wait that ran out leaves ready low: count it and end the run.
        check({31'h0, hreadyout}, 32'h1);
        if (hreadyout !== 1'b1) summarize();
    endtask

    // One-cycle fault event: overspeed when ovs is set, alarm otherwise.
    task automatic pulse(input logic ovs);
        @(posedge hclk);
        if (ovs) begin
            ovs_ev <= 1'b1;
        end else begin
            alm_ev <= 1'b1;
        end
        @(posedge hclk);
        {ovs_ev, alm_ev} <= 2'b00;
    endtask

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, seen, ovs_ev, alm_ev} = 5'h0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwdata = 32'h0;
        engine_speed = 16'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        check({31'h0, io_locked}, 32'h1);
        check({31'h0, mixture_close}, 32'h1);
        check({16'h0, speed_ref}, 32'h05dc);
        bus(1'b1, `EDCL_OFF_SPD_LIM, 32'h05e0_05d8);
        bus(1'b1, `EDCL_OFF_RATE, 32'h0010_0010);
        bus(1'b0, `EDCL_OFF_SPD_LIM, 32'h0);
        check(rd, 32'h05e0_05d8);
        bus(1'b0, 12'h0fc, 32'h0);
        check(rd, 32'h0);
        // Run closed during boot must not open the fuel path.
        sw_u.flip(RUN, 1'b1);
        check({31'h0, fuel_enable}, 32'h0);
        wait1(io_locked, 1'b0);
        wait1(fuel_enable, 1'b1);
        repeat (20) @(negedge hclk);
        check({31'h0, pick_flt}, 32'h0);
        wait1(pick_flt, 1'b1);
        @(posedge hclk);
        seen <= 1'b1;
        sw_u.flip(RST, 1'b1);
        wait1(pick_flt, 1'b0);
        sw_u.flip(RST, 1'b0);
        // Let the reset contact settle open so that only the software command clears.
        repeat (8) @(posedge hclk);
        pulse(1'b0);
        wait1(alarm_latched, 1'b1);
        repeat (10) @(negedge hclk);
        check({31'h0, alarm_latched}, 32'h1);
        bus(1'b1, `EDCL_OFF_CTRL, 32'h1);
        wait1(alarm_latched, 1'b0);
        $display("test faults done");
        // Overspeed reset only clears at standstill.
        @(posedge hclk);
        engine_speed <= 16'h0064;
        pulse(1'b1);
        wait1(overspeed_sd, 1'b1);
        sw_u.flip(RST, 1'b1);
        sw_u.flip(RST, 1'b0);
        repeat (10) @(negedge hclk);
        check({31'h0, overspeed_sd}, 32'h1);
        @(posedge hclk);
        engine_speed <= 16'h0;
        sw_u.flip(RST, 1'b1);
        wait1(overspeed_sd, 1'b0);
        sw_u.flip(RST, 1'b0);
        $display("test overspeed done");
        // Speed ramps saturate at the upper limit, reach the lower limit and stop on release.
        sw_u.flip(RAISE, 1'b1);
        wait16(speed_ref, 16'h05e0);
        repeat (20) @(negedge hclk);
        check({16'h0, speed_ref}, 32'h05e0);
        sw_u.flip(RAISE, 1'b0);
        sw_u.flip(LOWER, 1'b1);
        wait16(speed_ref, 16'h05d8);
        sw_u.flip(LOWER, 1'b0);
        sw_u.flip(RAISE, 1'b1);
        wait16(speed_ref, 16'h05d9);
        sw_u.flip(RAISE, 1'b0);
        repeat (10) @(negedge hclk);
        v = speed_ref;
        repeat (30) @(negedge hclk);
        check({16'h0, speed_ref}, {16'h0, v});
        $display("test speed ramp done");
        // Breaker, load/unload and load-only modes.
        sw_u.flip(BRK, 1'b1);
        wait1(isoch_mode, 1'b1);
        check({31'h0, dynamics_set2}, 32'h1);
        sw_u.flip(LU, 1'b1);
        wait16(load_ref, `EDCL_SHARE_LEVEL);
        check({31'h0, load_sharing_en}, 32'h1);
        sw_u.flip(LU, 1'b0);
        wait16(load_ref, `EDCL_UNLOAD_LEVEL);
        sw_u.flip(LU, 1'b1);
        sw_u.flip(LOC, 1'b1);
        wait1(load_only_mode, 1'b1);
        check({31'h0, load_sharing_en}, 32'h0);
        sw_u.flip(BASE, 1'b1);
        wait1(base_load_mode, 1'b1);
        wait16(load_ref, `EDCL_LOAD_SET_RESET);
        sw_u.flip(RAISE, 1'b1);
        bus(1'b1, `EDCL_OFF_LOAD_SET, 32'h0300);
        repeat (30) @(negedge hclk);
        check({16'h0, load_ref}, 32'h0200);
        sw_u.flip(RAISE, 1'b0);
        sw_u.flip(BASE, 1'b0);
        wait1(base_load_mode, 1'b0);
        repeat (20) @(negedge hclk);
        check({16'h0, load_ref}, 32'h0200);
        sw_u.flip(RAISE, 1'b1);
        repeat (30) @(negedge hclk);
        sw_u.flip(RAISE, 1'b0);
        check({31'h0, load_ref > 16'h0200}, 32'h1);
        v = load_ref;
        sw_u.flip(LOWER, 1'b1);
        repeat (30) @(negedge hclk);
        sw_u.flip(LOWER, 1'b0);
        check({31'h0, load_ref < v}, 32'h1);
        sw_u.flip(BASE, 1'b1);
        wait16(load_ref, 16'h0300);
        sw_u.flip(BRK, 1'b0);
        wait1(base_load_mode, 1'b0);
        check({31'h0, load_only_mode}, 32'h0);
        $display("test load modes done");
        // Alternate function turns the base-load contact into open loop.
        bus(1'b1, `EDCL_OFF_CFG, 32'h0000_00ee);
        bus(1'b0, `EDCL_OFF_CFG, 32'h0);
        check(rd, 32'h0000_00ee);
        sw_u.flip(BRK, 1'b1);
        wait1(gql_en, 1'b0);
        sw_u.flip(BASE, 1'b0);
        wait1(gql_en, 1'b1);
        sw_u.flip(RUN, 1'b0);
        wait1(mixture_close, 1'b1);
        check({31'h0, fuel_enable}, 32'h0);
        $display("test open loop and stop done");
        summarize();
    end
endmodule
